// ===== rtl/fsps_cfg.svh
`ifndef FSPS_CFG_SVH
`define FSPS_CFG_SVH

// control/status bit positions
`define FSPS_BIT_EN      0
`define FSPS_BIT_BUSY    6
// writable bits of the control/status byte, busy flag is read-only
`define FSPS_CTL_WMASK   8'hbf
// command codes held in bits 5..0 of the control/status byte
`define FSPS_CODE_LOAD   6'h01
`define FSPS_CODE_ERASE  6'h03
`define FSPS_CODE_WRITE  6'h05
`define FSPS_CODE_REEN   6'h11
// issue window after the control write, in cpu cycles
`define FSPS_ISSUE_WINDOW 4
// application reset address when the boot vector fuse is unprogrammed
`define FSPS_APP_RESET_ADDR 16'h0000
// default boot loader reset word address and first no-read-while-write page
`define FSPS_BOOT_RESET_DEF 16'h7000
`define FSPS_NO_READ_WHILE_WRITE_REGION_PAGE_DEF  224
// default widths: 32k words of program space, 128 words per page
`define FSPS_PC_W_DEF    15
`define FSPS_WORD_W_DEF  7

`endif

// ===== rtl/fsps_pkg.sv
package fsps_pkg;

	// sequencer states
	typedef enum logic [1:0] {
		FSPS_IDLE,
		FSPS_ARMED,
		FSPS_BUSY
	} fsps_state_e;

	// one program word as loaded from the register pair
	typedef logic [15:0] fsps_word_t;

endpackage : fsps_pkg

// ===== rtl/fsps_page_buffer.sv
`timescale 1ns/100ps
`default_nettype none

module fsps_page_buffer #(
	parameter int WORD_W = 7,
	parameter int DATA_W = 16
) (
	// clock and reset
	input  wire logic                ref_clk_i,
	input  wire logic                rstn_i,
	// control
	input  wire logic                clr_i,
	input  wire logic                wr_i,
	input  wire logic [WORD_W-1:0]   wr_idx_i,
	input  wire logic [DATA_W-1:0]   wr_data_i,
	// read port for the page write
	input  wire logic [WORD_W-1:0]   rd_idx_i,
	output logic      [DATA_W-1:0]   rd_data_o,
	// status
	output logic                     any_loaded_o
);

	localparam int DEPTH = 1 << WORD_W;

	logic [DATA_W-1:0] mem_q    [DEPTH];
	logic [DEPTH-1:0]  loaded_q;

	// one entry per word; a loaded entry refuses a second load until cleared
	// so a repeated address cannot corrupt an earlier word
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge ref_clk_i) begin
			if (!rstn_i || clr_i) begin
				loaded_q[i] <= 1'b0;
				mem_q[i]    <= '1;
			end else if (wr_i && wr_idx_i == WORD_W'(i) && !loaded_q[i]) begin
				loaded_q[i] <= 1'b1;
				mem_q[i]    <= wr_data_i;
			end
		end
	end

	// registered read, erased flash value for words never loaded
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			rd_data_o <= '1;
		end else begin
			rd_data_o <= mem_q[rd_idx_i];
		end
	end

	// live status: a registered copy would miss a load made one cycle
	// before an eeprom write, leaving stale words in the buffer
	assign any_loaded_o = |loaded_q;

endmodule : fsps_page_buffer

`default_nettype wire

// ===== rtl/fsps_sequencer.sv
// Overview of operation
// - fuse 1 starts at application address zero, fuse 0 at boot loader address
// - fuses are inputs only; the processor has no path to change them
// - pointer is low and high bytes; extension byte used only above 64k bytes
// - low pointer field selects word in page, high field selects the page
// - target page is latched at command issue; pointer may then change
// - program loads use a byte address; bit zero picks the byte
// - buffer words may be loaded in any order
// - erase code plus store within four cycles uses page field only
// - erase to shared region keeps reads; erase to other region halts cpu
// - load code plus store within four cycles writes buffer at word field
// - buffer cleared after page write, region re-enable and reset
// - each buffer word loads once between clears; repeats are ignored
// - an eeprom write during page loading discards the loaded buffer
// - write code plus store within four cycles programs page, data ignored
// - write to shared region keeps reads; write to other region halts cpu
// - enable and command bits self-clear if no store within four cycles
// - region busy flag reads one while the shared region is blocked
`include "fsps_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module fsps_sequencer #(
	parameter int          PC_W       = `FSPS_PC_W_DEF,
	parameter int          WORD_W     = `FSPS_WORD_W_DEF,
	parameter int          NO_READ_WHILE_WRITE_REGION_PAGE  = `FSPS_NO_READ_WHILE_WRITE_REGION_PAGE_DEF,
	parameter logic [15:0] BOOT_RESET = `FSPS_BOOT_RESET_DEF
) (
	// clock and reset
	input  wire logic                    ref_clk_i,
	input  wire logic                    rstn_i,
	// boot vector fuse pin and reset vector
	input  wire logic                    boot_vector_fuse_i,
	output logic      [15:0]             reset_vector_o,
	// control/status byte access
	input  wire logic                    ctl_wr_i,
	input  wire logic [7:0]              ctl_wdata_i,
	output logic      [7:0]              ctl_rdata_o,
	// store-program instruction with pointer and data pair
	input  wire logic                    store_prog_i,
	input  wire logic [7:0]              pointer_low_byte_i,
	input  wire logic [7:0]              pointer_high_byte_i,
	input  wire logic [7:0]              pointer_extension_byte_i,
	input  wire fsps_pkg::fsps_word_t    data_word_i,
	// load-program instruction
	input  wire logic                    load_prog_i,
	output logic      [PC_W-1:0]         load_word_addr_o,
	output logic                         load_byte_hi_o,
	// eeprom write event
	input  wire logic                    eeprom_wr_i,
	// flash array
	output logic                         flash_erase_o,
	output logic                         flash_write_o,
	output logic      [PC_W-WORD_W-1:0]  flash_page_o,
	input  wire logic                    flash_done_i,
	input  wire logic [WORD_W-1:0]       flash_word_idx_i,
	output fsps_pkg::fsps_word_t         flash_word_data_o,
	// processor halt
	output logic                         cpu_halt_o
);

	import fsps_pkg::*;

	localparam int PAGE_W = PC_W - WORD_W;
	localparam int WIN    = `FSPS_ISSUE_WINDOW;

	fsps_state_e         state_q;
	logic [2:0]          win_cnt_q;
	logic [7:0]          ctl_q;
	logic                busy_q;
	logic                halt_q;
	logic                erase_q;
	logic                write_q;
	logic                op_write_q;
	logic [PAGE_W-1:0]   page_q;
	logic                fuse_s1_q;
	logic                fuse_s2_q;
	logic [23:0]         zptr;
	logic [PAGE_W-1:0]   z_page;
	logic [WORD_W-1:0]   z_word;
	logic                issue;
	logic [5:0]          cmd;
	logic                buf_wr;
	logic                buf_clr;
	logic                buf_any;
	logic                reen_wr;

	// pointer assembly; extension byte only counts above 64k bytes
	assign zptr   = {(PC_W > 15) ? pointer_extension_byte_i : 8'h00,
		pointer_high_byte_i, pointer_low_byte_i};
	// word field above the byte bit, page field above that
	assign z_word = zptr[WORD_W:1];
	assign z_page = zptr[PC_W:WORD_W+1];

	assign cmd     = ctl_q[5:0];
	assign issue   = (state_q == FSPS_ARMED) && store_prog_i;
	assign reen_wr = ctl_wr_i && (state_q != FSPS_BUSY)
		&& ctl_wdata_i[5:0] == `FSPS_CODE_REEN;

	// load only when the full byte matches the load code
	assign buf_wr  = issue && cmd == `FSPS_CODE_LOAD && !ctl_q[7];
	// clears: page write done, re-enable, eeprom write while loading
	assign buf_clr = (state_q == FSPS_BUSY && flash_done_i && op_write_q)
		|| reen_wr
		|| (eeprom_wr_i && buf_any);

	// temporary page buffer, any load order accepted
	fsps_page_buffer #(
		.WORD_W (WORD_W),
		.DATA_W (16)
	) u_buf (
		.ref_clk_i    (ref_clk_i),
		.rstn_i       (rstn_i),
		.clr_i        (buf_clr),
		.wr_i         (buf_wr),
		.wr_idx_i     (z_word),
		.wr_data_i    (data_word_i),
		.rd_idx_i     (flash_word_idx_i),
		.rd_data_o    (flash_word_data_o),
		.any_loaded_o (buf_any)
	);

	// command sequencer; the window counter bounds the issue slot
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			state_q    <= FSPS_IDLE;
			win_cnt_q  <= 3'h0;
			ctl_q      <= 8'h00;
			erase_q    <= 1'b0;
			write_q    <= 1'b0;
			halt_q     <= 1'b0;
			op_write_q <= 1'b0;
			page_q     <= '0;
		end else begin
			erase_q <= 1'b0;
			write_q <= 1'b0;
			unique case (state_q)
				FSPS_IDLE: begin
					if (ctl_wr_i && !reen_wr && ctl_wdata_i[`FSPS_BIT_EN]) begin
						ctl_q     <= ctl_wdata_i & `FSPS_CTL_WMASK;
						win_cnt_q <= 3'h0;
						state_q   <= FSPS_ARMED;
					end else if (ctl_wr_i) begin
						ctl_q <= ctl_wdata_i & `FSPS_CTL_WMASK & 8'h80;
					end
				end
				FSPS_ARMED: begin
					if (store_prog_i) begin
						if (cmd == `FSPS_CODE_ERASE || cmd == `FSPS_CODE_WRITE) begin
							// latch target so the pointer is free again
							page_q     <= z_page;
							op_write_q <= cmd == `FSPS_CODE_WRITE;
							erase_q    <= cmd == `FSPS_CODE_ERASE;
							write_q    <= cmd == `FSPS_CODE_WRITE;
							// halt only for the no-read-while-write region
							halt_q     <= int'(z_page) >= NO_READ_WHILE_WRITE_REGION_PAGE;
							state_q    <= FSPS_BUSY;
						end else begin
							ctl_q   <= ctl_q & 8'h80;
							state_q <= FSPS_IDLE;
						end
					end else if (int'(win_cnt_q) == WIN - 1) begin
						// no store in time: drop enable and command
						ctl_q   <= ctl_q & 8'h80;
						state_q <= FSPS_IDLE;
					end else begin
						win_cnt_q <= win_cnt_q + 3'h1;
					end
				end
				FSPS_BUSY: begin
					if (flash_done_i) begin
						// completion drops enable and the halt together
						ctl_q   <= ctl_q & 8'h80;
						halt_q  <= 1'b0;
						state_q <= FSPS_IDLE;
					end
				end
			endcase
		end
	end

	// region busy flag: set by an erase or page write on the shared region, held
	// after completion until software re-enables it, so stale reads fail safe
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			busy_q <= 1'b0;
		end else if (issue && (cmd == `FSPS_CODE_ERASE
				|| cmd == `FSPS_CODE_WRITE) && int'(z_page) < NO_READ_WHILE_WRITE_REGION_PAGE) begin
			busy_q <= 1'b1;
		end else if (reen_wr) begin
			busy_q <= 1'b0;
		end
	end

	// status read-back
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			ctl_rdata_o <= 8'h00;
		end else begin
			ctl_rdata_o <= ctl_q;
			ctl_rdata_o[`FSPS_BIT_BUSY] <= busy_q;
		end
	end

	// fuse pin crosses in through two flops; no write path exists
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			fuse_s1_q <= 1'b1;
			fuse_s2_q <= 1'b1;
		end else begin
			fuse_s1_q <= boot_vector_fuse_i;
			fuse_s2_q <= fuse_s1_q;
		end
	end

	// reset vector from the synchronised fuse
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			reset_vector_o <= `FSPS_APP_RESET_ADDR;
		end else begin
			reset_vector_o <= fuse_s2_q ? `FSPS_APP_RESET_ADDR : BOOT_RESET;
		end
	end

	// program loads address bytes: bit zero picks the byte
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			load_word_addr_o <= '0;
			load_byte_hi_o   <= 1'b0;
		end else if (load_prog_i) begin
			load_word_addr_o <= zptr[PC_W:1];
			load_byte_hi_o   <= zptr[0];
		end
	end

	// flash strobes and page straight from flops
	assign flash_erase_o = erase_q;
	assign flash_write_o = write_q;
	assign flash_page_o  = page_q;
	assign cpu_halt_o    = halt_q;

	// checks
	AST_WINDOW_EXPIRE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(state_q == FSPS_ARMED && int'(win_cnt_q) == WIN - 1 && !store_prog_i)
		|=> !ctl_q[`FSPS_BIT_EN] ##1 !ctl_rdata_o[`FSPS_BIT_EN])
		else $error("enable did not self-clear after the issue window");

	AST_WINDOW_LEN: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(state_q == FSPS_ARMED) && !store_prog_i
		##1 !store_prog_i ##1 !store_prog_i ##1 !store_prog_i
		|=> state_q == FSPS_IDLE)
		else $error("armed state outlived four cycles");

	AST_RESET_VECTOR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		fuse_s2_q [*2] |-> reset_vector_o == `FSPS_APP_RESET_ADDR)
		else $error("unprogrammed fuse must give application reset");

	AST_BOOT_VECTOR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!fuse_s2_q [*2] |-> reset_vector_o == BOOT_RESET)
		else $error("programmed fuse must give boot loader reset");

	AST_HALT_NO_READ_WHILE_WRITE_REGION: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		issue && (cmd == `FSPS_CODE_ERASE || cmd == `FSPS_CODE_WRITE)
		|=> cpu_halt_o == (int'(page_q) >= NO_READ_WHILE_WRITE_REGION_PAGE))
		else $error("halt does not match target region");

	AST_DONE_RELEASE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		state_q == FSPS_BUSY && flash_done_i
		|=> !cpu_halt_o && !ctl_q[`FSPS_BIT_EN] ##1 !ctl_rdata_o[0])
		else $error("completion did not release halt and enable");

	AST_PAGE_HELD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		state_q == FSPS_BUSY && $past(state_q) == FSPS_BUSY
		|-> $stable(flash_page_o))
		else $error("latched page changed during operation");

	AST_BUSY_FLAG: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		issue && cmd == `FSPS_CODE_ERASE && int'(z_page) < NO_READ_WHILE_WRITE_REGION_PAGE
		|=> ##1 ctl_rdata_o[`FSPS_BIT_BUSY])
		else $error("busy flag not shown for shared region");

	AST_EEPROM_DISCARD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		eeprom_wr_i && buf_any && !buf_wr |=> !buf_any)
		else $error("eeprom write did not discard buffer");

	AST_REEN_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		reen_wr |=> !busy_q && !buf_any)
		else $error("re-enable did not clear buffer and busy");

	AST_BYTE_SEL: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		load_prog_i |=> load_byte_hi_o == $past(pointer_low_byte_i[0]))
		else $error("byte select not taken from pointer bit zero");

endmodule : fsps_sequencer

`default_nettype wire

// ===== testbench/fsps_flash_model.sv
`timescale 1ns/100ps
`default_nettype none

// flash array stand-in: sweeps the buffer on a page write, then finishes
module fsps_flash_model (
	// clock
	input  wire logic        ref_clk_i,
	// requests from the sequencer, delay from the testbench
	input  wire logic        flash_erase_i,
	input  wire logic        flash_write_i,
	input  wire logic [15:0] word_data_i,
	input  wire logic [7:0]  delay_i,
	// answers
	output logic             flash_done_o,
	output logic [2:0]       word_idx_o
);
	logic [15:0] page_q [8];
	bit          wr;
	int          i;

	// one operation at a time; idle index keeps moving so stale data shows
	initial begin
		flash_done_o = 1'b0;
		word_idx_o = 3'h0;
		forever begin
			@(posedge ref_clk_i);
			if (flash_erase_i || flash_write_i) begin
				wr = flash_write_i;
				#1;
				if (wr) begin
					for (i = 0; i < 8; i++) begin
						word_idx_o = 3'(i);
						@(posedge ref_clk_i);
						#1 page_q[i] = word_data_i;
					end
				end
				repeat (delay_i) @(posedge ref_clk_i);
				#1 flash_done_o = 1'b1;
				@(posedge ref_clk_i);
				#1 flash_done_o = 1'b0;
			end else begin
				word_idx_o <= word_idx_o + 3'h1;
			end
		end
	end
endmodule : fsps_flash_model

`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import fsps_pkg::*;
	localparam logic [15:0] BOOT = 16'h7000;
	localparam int          NO_READ_WHILE_WRITE_REGION = 8;

	logic        ref_clk_i, rstn_i, boot_vector_fuse_i, ctl_wr_i;
	logic        store_prog_i, load_prog_i, eeprom_wr_i, flash_done_i;
	logic        load_byte_hi_o, flash_erase_o, flash_write_o, cpu_halt_o;
	logic [7:0]  ctl_wdata_i, ctl_rdata_o, dly;
	logic [7:0]  pointer_low_byte_i, pointer_high_byte_i;
	logic [7:0]  pointer_extension_byte_i;
	logic [15:0] reset_vector_o;
	logic [14:0] load_word_addr_o;
	logic [11:0] flash_page_o;
	logic [2:0]  flash_word_idx_i;
	fsps_word_t  data_word_i, flash_word_data_o;
	logic [15:0] rbuf [8];
	bit          rld [8];
	int          fails, tests_run, cyc, i;

	fsps_sequencer #(.PC_W(15), .WORD_W(3), .NO_READ_WHILE_WRITE_REGION_PAGE(NO_READ_WHILE_WRITE_REGION),
		.BOOT_RESET(BOOT)) dut (.ref_clk_i, .rstn_i, .boot_vector_fuse_i,
		.reset_vector_o, .ctl_wr_i, .ctl_wdata_i, .ctl_rdata_o,
		.store_prog_i, .pointer_low_byte_i, .pointer_high_byte_i,
		.pointer_extension_byte_i, .data_word_i, .load_prog_i,
		.load_word_addr_o, .load_byte_hi_o, .eeprom_wr_i, .flash_erase_o,
		.flash_write_o, .flash_page_o, .flash_done_i, .flash_word_idx_i,
		.flash_word_data_o, .cpu_halt_o);

	fsps_flash_model fm (.ref_clk_i, .flash_erase_i(flash_erase_o),
		.flash_write_i(flash_write_o), .word_data_i(flash_word_data_o),
		.delay_i(dly), .flash_done_o(flash_done_i),
		.word_idx_o(flash_word_idx_i));

	// 100 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// reference buffer: unloaded words read back as all ones
	task automatic clr_ref;
		for (int k = 0; k < 8; k++) begin
			rbuf[k] = 16'hffff;
			rld[k] = 1'b0;
		end
	endtask : clr_ref

	// control write, gap idle cycles, then the store instruction
	task automatic cmd(input logic [5:0] code, input logic [11:0] pg,
		input logic [2:0] w, input logic [15:0] d, input int gap);
		ctl_wr_i = 1'b1;
		ctl_wdata_i = {2'b00, code};
		@(posedge ref_clk_i);
		#1 ctl_wr_i = 1'b0;
		repeat (gap) begin
			@(posedge ref_clk_i);
			#1;
		end
		{pointer_high_byte_i, pointer_low_byte_i} = {pg, w, 1'b0};
		data_word_i = d;
		store_prog_i = 1'b1;
		@(posedge ref_clk_i);
		#1 store_prog_i = 1'b0;
		// first load of a word wins, late stores do nothing
		if (code == 6'h01 && gap < 4 && !rld[w]) begin
			rbuf[w] = d;
			rld[w] = 1'b1;
		end
	endtask : cmd

	// erase or page write, run to completion with a random flash delay
	task automatic op(input logic [5:0] code, input logic [11:0] pg);
		int k;
		k = 0;
		dly = 8'($urandom_range(0, 20));
		cmd(code, pg, 3'h0, 16'($urandom), 3);
		{pointer_high_byte_i, pointer_low_byte_i} = 16'($urandom);
		cmp(code == 6'h03 ? flash_erase_o : flash_write_o, 1);
		cmp(16'(flash_page_o), 16'(pg));
		cmp(cpu_halt_o, pg >= NO_READ_WHILE_WRITE_REGION);
		if (pg < NO_READ_WHILE_WRITE_REGION) begin
			@(posedge ref_clk_i);
			#1 cmp(ctl_rdata_o[6], 1);
		end
		// sample done at the edge, where the sequencer takes it
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (flash_done_i !== 1'b1 && k < 200);
		if (flash_done_i !== 1'b1) begin
			fails++;
			report_and_stop();
		end
		#1 cmp(16'(flash_page_o), 16'(pg));
		cmp(cpu_halt_o, 0);
		@(posedge ref_clk_i);
		#1 cmp(ctl_rdata_o[0], 0);
		if (code == 6'h05) begin
			for (int j = 0; j < 8; j++)
				cmp(fm.page_q[j], rbuf[j]);
			clr_ref();
		end
	endtask : op

	// hang guard, tests need a few hundred cycles
	initial begin
		cyc = 0;
		forever begin
			@(posedge ref_clk_i);
			cyc++;
			if (cyc == 20000) begin
				fails++;
				report_and_stop();
			end
		end
	end

	initial begin
		void'($urandom(25));
		{rstn_i, ctl_wr_i, store_prog_i, load_prog_i, eeprom_wr_i} = 5'h00;
		boot_vector_fuse_i = 1'b1;
		ctl_wdata_i = 8'h00;
		{pointer_high_byte_i, pointer_low_byte_i} = 16'h0000;
		pointer_extension_byte_i = 8'($urandom);
		data_word_i = 16'h0000;
		dly = 8'h00;
		fails = 0;
		tests_run = 0;
		clr_ref();
		repeat (6) @(posedge ref_clk_i);
		#1 rstn_i = 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1 cmp(reset_vector_o, 16'h0000);
		boot_vector_fuse_i = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		#1 cmp(reset_vector_o, BOOT);
		// fill out of order with a repeat, erase, then write a shared page
		for (i = 0; i < 8; i++)
			cmd(6'h01, 12'h3, 3'(i * 3), 16'($urandom), $urandom_range(0, 3));
		cmd(6'h01, 12'h3, 3'h6, 16'($urandom), 0);
		op(6'h03, 12'h3);
		op(6'h05, 12'h3);
		// page in the halting region, buffer left empty by the last write
		op(6'h03, 12'h9);
		op(6'h05, 12'h9);
		// late store is dropped and the enable bit clears itself
		cmd(6'h01, 12'h5, 3'h2, 16'($urandom), 4);
		cmp(ctl_rdata_o[0], 0);
		cmd(6'h01, 12'h5, 3'h1, 16'($urandom), 1);
		eeprom_wr_i = 1'b1;
		@(posedge ref_clk_i);
		#1 eeprom_wr_i = 1'b0;
		clr_ref();
		cmd(6'h01, 12'h5, 3'h4, 16'($urandom), 2);
		op(6'h03, 12'h5);
		op(6'h05, 12'h5);
		// region re-enable drops the busy flag and the loaded words
		cmd(6'h01, 12'h4, 3'h7, 16'($urandom), 0);
		ctl_wr_i = 1'b1;
		ctl_wdata_i = 8'h11;
		@(posedge ref_clk_i);
		#1 ctl_wr_i = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#1 cmp(ctl_rdata_o[6], 0);
		clr_ref();
		op(6'h03, 12'h4);
		op(6'h05, 12'h4);
		// a mid-run reset empties the buffer and restarts the fuse path
		cmd(6'h01, 12'h4, 3'h3, 16'($urandom), 0);
		rstn_i = 1'b0;
		@(posedge ref_clk_i);
		#1 rstn_i = 1'b1;
		clr_ref();
		repeat (4) @(posedge ref_clk_i);
		#1 cmp(reset_vector_o, BOOT);
		op(6'h03, 12'h4);
		op(6'h05, 12'h4);
		// program loads address bytes, strobe held across the loads
		load_prog_i = 1'b1;
		for (i = 0; i < 4; i++) begin
			{pointer_high_byte_i, pointer_low_byte_i} = 16'($urandom);
			@(posedge ref_clk_i);
			#1 cmp(16'(load_word_addr_o), 16'(pointer_high_byte_i * 128 +
				pointer_low_byte_i / 2));
			cmp(load_byte_hi_o, pointer_low_byte_i[0]);
		end
		load_prog_i = 1'b0;
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
